// ===== rtl/flash_erase_seq.sv
// Purpose: erase, deep sleep and wake/id command handling of a serial flash
// Assumes: serial pins asynchronous to i_core_clk; link clock well below core clock
// Notes: array erase itself is done by the caller on o_erase_req
module flash_erase_seq
	import flash_erase_pkg::*;
#(
	parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
	parameter int unsigned BLOCK32_CYCLES = BLOCK32_ERASE_CYCLES,
	parameter int unsigned BLOCK64_CYCLES = BLOCK64_ERASE_CYCLES,
	parameter int unsigned CHIP_CYCLES = CHIP_ERASE_CYCLES,
	parameter logic [31:0] ARRAY_BYTES = 32'h00080000,
	// Arbitrary value, not any real part's code
	parameter logic [7:0] DEVICE_ID = 8'h5a
) (
	input wire logic i_core_clk, // Core clock
	input wire logic i_reset_n, // Async reset, active low
	input wire spi_pins_t i_spi, // Chip-select, serial clock, serial in
	input wire logic i_write_enable_cmd, // Pulse: write enable decoded
	input wire logic i_high_perf_cmd, // Pulse: high performance entered
	input wire logic i_other_busy, // Program or write cycle running
	input wire logic [4:0] i_protect_bits, // Block protect bits 4..0
	output logic o_so, // Serial data out
	output logic o_so_oe_n, // Low while driving serial out
	output logic o_write_in_progress_flag, // Erase cycle running
	output logic o_write_enable_latch, // Write enable latch
	output logic o_high_perf_state, // High performance state
	output logic o_deep_sleep, // In deep sleep
	output logic o_standby, // Deselected and idle
	output logic o_cmd_rejected, // Pulse: frame discarded
	output erase_req_t o_erase_req // Erase start, valid one cycle
);
	spi_pins_t pin_meta;
	spi_pins_t pin_sync;
	spi_pins_t pin_prev;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic selected;
	logic [5:0] bit_cnt;
	logic [31:0] shift_in;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [2:0] id_idx;
	power_state_t state;
	power_state_t next_state;
	logic [31:0] timer;
	logic [31:0] next_timer;
	logic timer_done;
	logic wel_clear;
	logic is_erase_op;
	erase_kind_t op_kind;
	logic [5:0] need_bits;
	logic [23:0] region_lo;
	logic [23:0] region_hi;
	logic region_prot;
	logic go_erase;
	logic go_sleep;
	logic go_wake;
	logic hp_clear;
	logic id_ok;
	logic known_op;
	logic asleep;

	function automatic logic [23:0] region_mask(input erase_kind_t kind);
		case (kind)
			KIND_SECTOR: region_mask = MASK_SECTOR;
			KIND_BLOCK32: region_mask = MASK_BLOCK32;
			KIND_BLOCK64: region_mask = MASK_BLOCK64;
			default: region_mask = MASK_CHIP;
		endcase
	endfunction

	// Protected span grows from the top, or bottom when bit 3 is set
	function automatic logic overlaps_protect(input logic [4:0] bp, input logic [23:0] lo,
		input logic [23:0] hi);
		logic [31:0] unit;
		logic [31:0] span;
		unit = bp[4] ? PROT_UNIT_SECTOR : PROT_UNIT_BLOCK;
		span = (bp[2:0] == 3'h0) ? 32'h0 : (unit << (bp[2:0] - 3'h1));
		if (span > ARRAY_BYTES) begin
			span = ARRAY_BYTES;
		end
		if (span == 32'h0) begin
			overlaps_protect = 1'b0;
		end else if (bp[3]) begin
			overlaps_protect = {8'h00, lo} < span;
		end else begin
			overlaps_protect = {8'h00, hi} >= (ARRAY_BYTES - span);
		end
	endfunction

	function automatic logic [31:0] erase_cycles(input erase_kind_t kind);
		case (kind)
			KIND_SECTOR: erase_cycles = SECTOR_CYCLES;
			KIND_BLOCK32: erase_cycles = BLOCK32_CYCLES;
			KIND_BLOCK64: erase_cycles = BLOCK64_CYCLES;
			default: erase_cycles = CHIP_CYCLES;
		endcase
	endfunction

	// Pins cross into the core clock through two flops
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_meta <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
			pin_sync <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
			pin_prev <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
		end else begin
			pin_meta <= i_spi;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign selected = ~pin_sync.cs_n;
	assign cs_fall = ~pin_sync.cs_n & pin_prev.cs_n;
	assign cs_rise = pin_sync.cs_n & ~pin_prev.cs_n;
	assign sclk_rise = selected & pin_sync.sclk & ~pin_prev.sclk;
	assign sclk_fall = selected & ~pin_sync.sclk & pin_prev.sclk;

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bit_cnt <= 6'h00;
			shift_in <= 32'h0;
			opcode <= 8'h00;
			addr <= 24'h000000;
		end else if (cs_fall) begin
			bit_cnt <= 6'h00;
			opcode <= 8'h00;
		end else if (sclk_rise) begin
			shift_in <= {shift_in[30:0], pin_sync.si};
			if (bit_cnt != BITS_MAX) begin
				bit_cnt <= bit_cnt + 6'h01;
			end
			if (bit_cnt == BITS_OPCODE - 6'h01) begin
				opcode <= {shift_in[6:0], pin_sync.si};
			end
			if (bit_cnt == BITS_WITH_ADDR - 6'h01) begin
				addr <= {shift_in[22:0], pin_sync.si};
			end
		end
	end

	always_comb begin
		is_erase_op = 1'b1;
		op_kind = KIND_CHIP;
		need_bits = BITS_OPCODE;
		case (opcode)
			OP_SECTOR_ERASE: begin
				op_kind = KIND_SECTOR;
				need_bits = BITS_WITH_ADDR;
			end
			OP_BLOCK32_ERASE: begin
				op_kind = KIND_BLOCK32;
				need_bits = BITS_WITH_ADDR;
			end
			OP_BLOCK64_ERASE: begin
				op_kind = KIND_BLOCK64;
				need_bits = BITS_WITH_ADDR;
			end
			OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
				op_kind = KIND_CHIP;
			end
			default: begin
				is_erase_op = 1'b0;
			end
		endcase
	end

	assign region_lo = (op_kind == KIND_CHIP) ? 24'h000000 : (addr & ~region_mask(op_kind));
	assign region_hi = region_lo | region_mask(op_kind);
	assign region_prot = overlaps_protect(i_protect_bits, region_lo, region_hi);

	assign go_erase = cs_rise && (state == ST_IDLE) && !i_other_busy && o_write_enable_latch
		&& is_erase_op && (bit_cnt == need_bits) && !region_prot;
	assign go_sleep = cs_rise && (state == ST_IDLE) && !i_other_busy
		&& (opcode == OP_DEEP_SLEEP) && (bit_cnt == BITS_OPCODE);
	assign go_wake = cs_rise && ((state == ST_SLEEP) || (state == ST_SLEEP_ENTRY))
		&& (opcode == OP_WAKE_ID) && ((bit_cnt == BITS_OPCODE) || (bit_cnt >= BITS_WITH_ADDR));
	assign hp_clear = cs_rise && (state == ST_IDLE) && !i_other_busy
		&& (opcode == OP_WAKE_ID) && (bit_cnt >= BITS_OPCODE);
	// Id streams after three dummy bytes
	assign id_ok = (opcode == OP_WAKE_ID) && (bit_cnt >= BITS_WITH_ADDR) && !i_other_busy
		&& ((state == ST_IDLE) || (state == ST_SLEEP));
	assign known_op = is_erase_op || (opcode == OP_DEEP_SLEEP) || (opcode == OP_WAKE_ID);
	assign timer_done = (timer == 32'h1);
	// Write enable and high perf ignored asleep or waking
	assign asleep = (state == ST_SLEEP) || (state == ST_WAKE);

	always_comb begin
		next_state = state;
		next_timer = (timer > 32'h0) ? timer - 32'h1 : 32'h0;
		case (state)
			ST_IDLE: begin
				if (go_erase) begin
					next_state = ST_ERASE;
					next_timer = erase_cycles(op_kind);
				end else if (go_sleep) begin
					next_state = ST_SLEEP_ENTRY;
					next_timer = SLEEP_ENTRY_CYCLES;
				end
			end
			ST_ERASE: begin
				if (timer_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_SLEEP_ENTRY: begin
				if (go_wake) begin
					next_state = ST_WAKE;
					next_timer = WAKE_CYCLES;
				end else if (timer_done) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (go_wake) begin
					// Wake delay, longer after an id read
					next_state = ST_WAKE;
					next_timer = (bit_cnt == BITS_OPCODE) ? WAKE_CYCLES : WAKE_WITH_ID_CYCLES;
				end
			end
			ST_WAKE: begin
				if (timer_done) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_timer = 32'h0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ST_IDLE;
			timer <= 32'h0;
		end else begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	// Latch dropped on first erase cycle
	assign wel_clear = (state == ST_ERASE) && (timer == erase_cycles(o_erase_req.kind));

	// Set wins so a write enable in the clearing cycle survives
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_write_enable_latch <= 1'b0;
		end else if (i_write_enable_cmd && !asleep) begin
			o_write_enable_latch <= 1'b1;
		end else if (wel_clear) begin
			o_write_enable_latch <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_high_perf_state <= 1'b0;
		end else if (i_high_perf_cmd && !asleep) begin
			o_high_perf_state <= 1'b1;
		end else if (hp_clear || go_wake) begin
			o_high_perf_state <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_erase_req <= '0;
		end else begin
			o_erase_req.valid <= go_erase;
			if (go_erase) begin
				o_erase_req.kind <= op_kind;
				o_erase_req.first_addr <= region_lo;
				o_erase_req.last_addr <= region_hi;
			end
		end
	end

	// Recognised frame that ended without taking effect
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cmd_rejected <= 1'b0;
		end else begin
			o_cmd_rejected <= cs_rise && known_op && !go_erase && !go_sleep && !go_wake
				&& !hp_clear && (bit_cnt != 6'h00);
		end
	end

	// Id out on falling edges, MSB first, repeating
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_so <= 1'b0;
			o_so_oe_n <= 1'b1;
			id_idx <= 3'h0;
		end else if (!selected) begin
			o_so_oe_n <= 1'b1;
			id_idx <= 3'h0;
		end else if (sclk_fall && id_ok) begin
			o_so <= DEVICE_ID[3'h7 - id_idx];
			o_so_oe_n <= 1'b0;
			id_idx <= id_idx + 3'h1;
		end
	end

	assign o_write_in_progress_flag = (state == ST_ERASE);
	assign o_deep_sleep = (state == ST_SLEEP);
	assign o_standby = pin_sync.cs_n && (state == ST_IDLE) && !i_other_busy;
endmodule

// ===== rtl/flash_erase_pkg.sv
// Purpose: constants and types for the serial flash erase and power-state sequencer
// Assumes: core clock 25 MHz, serial link sampled by the core clock
// Notes: erase times are plain defaults, shortened through module parameters
// Behaviour
// - 20H sector erase needs write enable latch set
// - Sector erase: opcode, three address bytes, any address
// - Chip-select must rise exactly after last address byte
// - Erase cycle holds busy flag, clears when done
// - Write enable latch cleared on the first erase cycle, unless a write enable pulse lands in that cycle
// - Protected sector is never erased
// - 52H erases 32KB block, enable and protect apply
// - D8H erases 64KB block, enable and protect apply
// - 60H or C7H chip erase, eight bits only
// - Chip erase only when nothing is protected
// - B9H alone enters deep sleep after delay
// - Deep sleep ignores everything except wake command
// - Chip-select high while idle means standby
// - Reset always lands in standby, not sleep
// - Sleep command needs chip-select rise after bit eight
// - Sleep command rejected while a cycle runs
// - Wake command alone, then wake delay
// - Wake command also leaves high performance state
// - Id read: three dummy bytes, id repeats MSB first
// - Wake or id ignored while busy
// - Serial input bits sampled on clock rising edge
package flash_erase_pkg;
	localparam int unsigned CLK_MHZ = 25;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE_ID = 8'hab;
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_WITH_ADDR = 6'h20;
	localparam logic [5:0] BITS_MAX = 6'h3f;
	localparam logic [23:0] MASK_SECTOR = 24'h000fff;
	localparam logic [23:0] MASK_BLOCK32 = 24'h007fff;
	localparam logic [23:0] MASK_BLOCK64 = 24'h00ffff;
	localparam logic [23:0] MASK_CHIP = 24'hffffff;
	localparam logic [31:0] PROT_UNIT_SECTOR = 32'h00001000;
	localparam logic [31:0] PROT_UNIT_BLOCK = 32'h00010000;
	localparam int unsigned SECTOR_ERASE_TIME_US = 1000;
	localparam int unsigned BLOCK32_ERASE_TIME_US = 2000;
	localparam int unsigned BLOCK64_ERASE_TIME_US = 3000;
	localparam int unsigned CHIP_ERASE_TIME_US = 8000;
	localparam int unsigned SLEEP_ENTRY_TIME_NS = 3000;
	localparam int unsigned WAKE_DELAY_NS = 3000;
	localparam int unsigned WAKE_WITH_ID_DELAY_NS = 5000;
	localparam int unsigned SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned BLOCK32_ERASE_CYCLES = BLOCK32_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned BLOCK64_ERASE_CYCLES = BLOCK64_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;
	// Longest delays, so rounded down
	localparam int unsigned SLEEP_ENTRY_CYCLES = SLEEP_ENTRY_TIME_NS * CLK_MHZ / 1000;
	localparam int unsigned WAKE_CYCLES = WAKE_DELAY_NS * CLK_MHZ / 1000;
	localparam int unsigned WAKE_WITH_ID_CYCLES = WAKE_WITH_ID_DELAY_NS * CLK_MHZ / 1000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ERASE = 5'h02,
		ST_SLEEP_ENTRY = 5'h04,
		ST_SLEEP = 5'h08,
		ST_WAKE = 5'h10
	} power_state_t;

	typedef enum logic [1:0] {
		KIND_SECTOR = 2'h0,
		KIND_BLOCK32 = 2'h1,
		KIND_BLOCK64 = 2'h2,
		KIND_CHIP = 2'h3
	} erase_kind_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic si;
	} spi_pins_t;

	typedef struct packed {
		logic valid;
		erase_kind_t kind;
		logic [23:0] first_addr;
		logic [23:0] last_addr;
	} erase_req_t;
endpackage

// ===== verif/flash_erase_props.sv
// Purpose: port-level checks of the erase and power-state sequencer
// Assumes: one core clock domain, async active-low reset
// Notes: erase lengths arrive as the design's own parameters
module flash_erase_props
	import flash_erase_pkg::*;
#(
	parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
	parameter int unsigned BLOCK32_CYCLES = BLOCK32_ERASE_CYCLES,
	parameter int unsigned BLOCK64_CYCLES = BLOCK64_ERASE_CYCLES,
	parameter int unsigned CHIP_CYCLES = CHIP_ERASE_CYCLES
) (
	input wire logic i_core_clk, // Core clock
	input wire logic i_reset_n, // Reset
	input wire spi_pins_t i_spi, // Pins
	input wire logic i_write_enable_cmd, // Enable pulse
	input wire logic [4:0] i_protect_bits, // Protect bits
	input wire logic o_so_oe_n, // Out enable
	input wire logic o_write_in_progress_flag, // Busy
	input wire logic o_write_enable_latch, // Latch
	input wire logic o_deep_sleep, // Sleep
	input wire logic o_standby, // Standby
	input wire erase_req_t o_erase_req // Erase start
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	logic [31:0] hi_cnt;
	logic [31:0] exp_len;
	erase_kind_t kind_q;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hi_cnt <= 32'h0;
		end else if (o_write_in_progress_flag) begin
			hi_cnt <= hi_cnt + 32'h1;
		end else begin
			hi_cnt <= 32'h0;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			kind_q <= KIND_SECTOR;
		end else if (o_erase_req.valid) begin
			kind_q <= o_erase_req.kind;
		end
	end
	always_comb begin
		case (kind_q)
			KIND_SECTOR: exp_len = SECTOR_CYCLES;
			KIND_BLOCK32: exp_len = BLOCK32_CYCLES;
			KIND_BLOCK64: exp_len = BLOCK64_CYCLES;
			default: exp_len = CHIP_CYCLES;
		endcase
	end
	chk_busy_on_start: assert property (
		o_erase_req.valid |-> o_write_in_progress_flag) else $error("busy low at start");
	chk_busy_length: assert property (
		$fell(o_write_in_progress_flag) |-> hi_cnt == exp_len) else $error("busy length");
	chk_latch_needed: assert property (
		o_erase_req.valid |-> o_write_enable_latch) else $error("erase without latch");
	chk_latch_cleared: assert property (
		o_erase_req.valid && !i_write_enable_cmd |=> !o_write_enable_latch)
		else $error("latch kept");
	chk_chip_unprot: assert property (
		o_erase_req.valid && o_erase_req.kind == KIND_CHIP |-> i_protect_bits[2:0] == 3'h0)
		else $error("chip erase while protected");
	chk_sector_span: assert property (
		o_erase_req.valid && o_erase_req.kind == KIND_SECTOR |->
		o_erase_req.first_addr[11:0] == 12'h0 &&
		o_erase_req.last_addr == (o_erase_req.first_addr | 24'h000fff))
		else $error("sector span");
	chk_sleep_quiet: assert property (
		o_deep_sleep |-> !o_erase_req.valid && !o_write_in_progress_flag)
		else $error("activity in sleep");
	chk_standby_apart: assert property (
		o_standby |-> !o_deep_sleep && !o_write_in_progress_flag) else $error("standby mix");
	chk_boot_standby: assert property (
		$rose(i_reset_n) |-> !o_deep_sleep) else $error("sleep after reset");
	chk_output_release: assert property (
		$rose(i_spi.cs_n) |-> ##[1:5] o_so_oe_n) else $error("serial out kept");
	cov_chip: cover property (o_erase_req.valid && o_erase_req.kind == KIND_CHIP);
	cov_sleep: cover property ($rose(o_deep_sleep));
	cov_id_out: cover property (!o_so_oe_n);
endmodule

bind flash_erase_seq flash_erase_props #(
	.SECTOR_CYCLES(SECTOR_CYCLES), .BLOCK32_CYCLES(BLOCK32_CYCLES),
	.BLOCK64_CYCLES(BLOCK64_CYCLES), .CHIP_CYCLES(CHIP_CYCLES)
) u_props (
	.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_spi(i_spi),
	.i_write_enable_cmd(i_write_enable_cmd), .i_protect_bits(i_protect_bits),
	.o_so_oe_n(o_so_oe_n), .o_write_in_progress_flag(o_write_in_progress_flag),
	.o_write_enable_latch(o_write_enable_latch), .o_deep_sleep(o_deep_sleep),
	.o_standby(o_standby), .o_erase_req(o_erase_req)
);

// ===== verif/flash_host_model.sv
// Purpose: serial host driving command frames into the sequencer
// Assumes: link clock 320 ns, stands still low between frames
// Notes: data line shows the inverse of its last bit while deselected
module flash_host_model
	import flash_erase_pkg::*;
(
	input wire logic i_core_clk, // Core clock
	input wire logic i_so, // Serial out of device
	output spi_pins_t o_pins // Driven pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx;
	initial o_pins = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
	task automatic frame(input logic [47:0] d, input int n);
		@(posedge i_core_clk);
		#1 o_pins.cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_pins.si = d[47 - i];
			#160 o_pins.sclk = 1'b1;
			rx = {rx[6:0], i_so};
			#160 o_pins.sclk = 1'b0;
		end
		#40 o_pins.cs_n = 1'b1;
		o_pins.si = ~o_pins.si;
	endtask
endmodule

// ===== verif/testbench.sv
// Purpose: self-checking bench of the erase and power-state sequencer
// Assumes: 25 MHz core clock, shortened erase cycles
// Notes: chip erase kept long so commands land while busy
module testbench
	import flash_erase_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ID_CODE = 8'h5a; // Arbitrary value
	logic clk, rst_n, we, hp, ob, so, oe_n, write_in_progress_flag, write_enable_latch, hps, ds, sb, rej;
	logic [4:0] bp;
	spi_pins_t pins;
	erase_req_t req;
	int n_mismatch, n_checks, n_req, n_rej, cyc;
	flash_erase_seq #(.SECTOR_CYCLES(20), .BLOCK32_CYCLES(30), .BLOCK64_CYCLES(40),
		.CHIP_CYCLES(400), .DEVICE_ID(ID_CODE)) u_dut (
		.i_core_clk(clk), .i_reset_n(rst_n), .i_spi(pins), .i_write_enable_cmd(we),
		.i_high_perf_cmd(hp), .i_other_busy(ob), .i_protect_bits(bp), .o_so(so),
		.o_so_oe_n(oe_n), .o_write_in_progress_flag(write_in_progress_flag), .o_write_enable_latch(write_enable_latch),
		.o_high_perf_state(hps), .o_deep_sleep(ds), .o_standby(sb),
		.o_cmd_rejected(rej), .o_erase_req(req));
	// Released serial out reads as the inverse, so a missing enable shows
	flash_host_model u_host (.i_core_clk(clk), .i_so(oe_n ? ~so : so), .o_pins(pins));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		n_req += (req.valid === 1'b1);
		n_rej += (rej === 1'b1);
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			close_out;
		end
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_reset;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
	endtask
	task automatic pulse(ref logic s);
		@(posedge clk);
		#1 s = 1'b1;
		@(posedge clk);
		#1 s = 1'b0;
	endtask
	task automatic erase(input logic [7:0] op, input logic [23:0] a, input int n, input bit en);
		if (en) pulse(we);
		u_host.frame({op, a, 16'h0}, n);
		repeat (10) @(posedge clk);
		#1;
	endtask
	task automatic wait_free;
		for (int i = 0; i < 600 && write_in_progress_flag !== 1'b0; i++) @(posedge clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] op, input int n, input int w);
		u_host.frame({op, 40'h0}, n);
		repeat (w) @(posedge clk);
		#1;
	endtask
	task automatic t_kinds;
		logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
		logic [23:0] msk [5] = '{24'hfff, 24'h7fff, 24'hffff, 24'hffffff, 24'hffffff};
		int r;
		for (int k = 0; k < 5; k++) begin
			r = n_req;
			erase(ops[k], 24'h05a5a5, (k > 2) ? 8 : 32, 1'b1);
			chk("erase started", r + 1, n_req);
			chk("kind", (k > 3) ? 3 : k, req.kind);
			chk("first addr", 24'h05a5a5 & ~msk[k], req.first_addr);
			chk("busy", 1, write_in_progress_flag);
			chk("latch", 0, write_enable_latch);
			wait_free;
			chk("busy end", 0, write_in_progress_flag);
		end
		$display("test kinds done");
	endtask
	task automatic t_refuse;
		int r = n_req;
		int j = n_rej;
		erase(8'h20, 24'h001000, 32, 1'b0);
		erase(8'h20, 24'h001000, 31, 1'b1);
		erase(8'h20, 24'h001000, 40, 1'b1);
		erase(8'h60, 24'h0, 16, 1'b1);
		bp = 5'h01;
		erase(8'h20, 24'h07f000, 32, 1'b1);
		erase(8'hc7, 24'h0, 8, 1'b1);
		chk("refusals", j + 6, n_rej);
		erase(8'h20, 24'h001000, 32, 1'b1);
		chk("open sector", r + 1, n_req);
		bp = 5'h00;
		wait_free;
		$display("test refuse done");
	endtask
	task automatic t_sleep;
		int r;
		cmd(8'hb9, 9, 90);
		chk("sleep odd count", 0, ds);
		cmd(8'hb9, 8, 60);
		chk("sleep early", 0, ds);
		repeat (30) @(posedge clk);
		#1;
		chk("sleep", 1, ds);
		chk("standby in sleep", 0, sb);
		r = n_req;
		erase(8'h20, 24'h0, 32, 1'b1);
		chk("erase in sleep", r, n_req);
		chk("latch in sleep", 0, write_enable_latch);
		cmd(8'hab, 8, 60);
		chk("woken", 0, ds);
		chk("wake delay", 0, sb);
		repeat (30) @(posedge clk);
		#1;
		chk("standby", 1, sb);
		cmd(8'hab, 48, 5);
		chk("id", ID_CODE, u_host.rx);
		cmd(8'hb9, 8, 90);
		cmd(8'hab, 48, 100);
		chk("id wake delay", 0, sb);
		repeat (40) @(posedge clk);
		#1;
		chk("id wake", 0, ds);
		chk("id wake standby", 1, sb);
		chk("id wake id", ID_CODE, u_host.rx);
		cmd(8'hb9, 8, 90);
		do_reset;
		chk("reset sleep", 0, ds);
		chk("reset standby", 1, sb);
		$display("test sleep done");
	endtask
	task automatic t_busy;
		pulse(hp);
		chk("high perf", 1, hps);
		erase(8'hc7, 24'h0, 8, 1'b1);
		cmd(8'hb9, 8, 0);
		cmd(8'hab, 8, 90);
		chk("sleep while busy", 0, ds);
		chk("wake while busy", 1, hps);
		chk("busy kept", 1, write_in_progress_flag);
		wait_free;
		ob = 1'b1;
		cmd(8'hb9, 8, 90);
		chk("sleep other busy", 0, ds);
		ob = 1'b0;
		cmd(8'hab, 8, 90);
		chk("high perf left", 0, hps);
		$display("test busy done");
	endtask
	initial begin
		{we, hp, ob, bp} = '0;
		{n_mismatch, n_checks, n_req, n_rej, cyc} = '0;
		do_reset;
		chk("boot standby", 1, sb);
		chk("boot oe", 1, oe_n);
		t_kinds;
		t_refuse;
		t_sleep;
		t_busy;
		close_out;
	end
endmodule
